// [hdl/blp_regs.svh]
// register offsets, field positions, reset values and timing constants
// assumes: included by bare name from the design files of the led pwm block
`ifndef BLP_REGS_SVH
`define BLP_REGS_SVH

`define BLP_OFF_CFG 8'h00
`define BLP_OFF_LIM 8'h04
`define BLP_OFF_DLY 8'h08
`define BLP_OFF_STEP 8'h0C
`define BLP_OFF_INTV 8'h10
`define BLP_OFF_SKEW 8'h14

`define BLP_CFG_SYM 16
`define BLP_CFG_WDT_HI 15
`define BLP_CFG_WDT_LO 8
`define BLP_CFG_RST 7
`define BLP_CFG_UPD 6
`define BLP_CFG_SIZE_HI 5
`define BLP_CFG_SIZE_LO 4
`define BLP_CFG_SYNC 3
`define BLP_CFG_CLK 2
`define BLP_CFG_CTRL_HI 1
`define BLP_CFG_CTRL_LO 0

`define BLP_LIM_MAX_HI 15
`define BLP_LIM_MAX_LO 8
`define BLP_LIM_MIN_HI 7
`define BLP_LIM_MIN_LO 0
`define BLP_DLY_HD_HI 23
`define BLP_DLY_HD_LO 12
`define BLP_DLY_LD_HI 11
`define BLP_DLY_LD_LO 0

`define BLP_CFG_RESET 32'h0000_1400
`define BLP_CFG_MASK 32'h0001_FF3F
`define BLP_LIM_MASK 32'h0000_FFFF
`define BLP_DLY_MASK 32'h00FF_FFFF
`define BLP_FULL_MASK 32'hFFFF_FFFF
`define BLP_SKEW_MASK 32'h0000_00FF
`define BLP_ZERO 32'h0000_0000

`define BLP_CTRL_OFF 2'h0
`define BLP_CTRL_BREATH 2'h1
`define BLP_CTRL_BLINK 2'h2
`define BLP_CTRL_ON 2'h3

`define BLP_TOP8 8'hFF
`define BLP_TOP7 8'hFE
`define BLP_TOP6 8'hFC
`define BLP_SIZE8 2'h0
`define BLP_SIZE7 2'h1
`define BLP_SIZE6 2'h2

`define BLP_CLK_NS 10
`define BLP_SLOW_NS 30518
`define BLP_SLOW_CYC (`BLP_SLOW_NS / `BLP_CLK_NS)
`define BLP_GUARD_MS 200
`define BLP_GUARD_CYC (`BLP_GUARD_MS * 1000000 / `BLP_CLK_NS)

`endif

// [hdl/blp_pkg.sv]
// types shared by the led pwm block
// assumes: compiled before every module of the block
package blp_pkg;
    typedef enum logic [1:0] {
        st_rise,
        st_hold_top,
        st_fall,
        st_hold_bot
    } blp_ramp_t;
endpackage

// [hdl/blp_stage_reg.sv]
// staged register: software writes a holding copy, copy moves it to active
// assumes: one clock, copy is a one-cycle pulse; reads use the active copy
`timescale 1ns/1ps
module blp_stage_reg #(
    parameter int W = 32,
    parameter logic [W-1:0] MASK = '1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_mask,
    input wire logic [W-1:0] wr_data,
    input wire logic copy,
    output logic [W-1:0] active_q
);
    logic [W-1:0] hold_q;
    wire [W-1:0] hold_d = ((hold_q & ~wr_mask) | (wr_data & wr_mask)) & MASK;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= '0;
        end else if (clr) begin
            hold_q <= '0;
        end else if (wr_en) begin
            hold_q <= hold_d;
        end
    end

    // a write in the copy cycle lands in the holding copy for the next period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= '0;
        end else if (clr) begin
            active_q <= '0;
        end else if (copy) begin
            active_q <= hold_q;
        end
    end
endmodule

// [hdl/blp_top.sv]
// breathing / blinking led pwm generator with an apb register slave
// assumes: pclk 100 MHz, apb inputs synchronous, sync_in is the or of the
// align bits of the other instances
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "blp_regs.svh"
module blp_top #(
    parameter int GUARD_TICK_CYC = `BLP_GUARD_CYC,
    parameter int SLOW_DIV = `BLP_SLOW_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sync_in,
    output logic sync_out,
    output logic led_out
);
    ////////////////////////////////////////////////////////////////////////
    // apb decode

    function automatic logic [3:0] seg_nib(input logic [31:0] w, input logic [2:0] i);
        seg_nib = w[{i, 2'b00} +: 4];
    endfunction

    wire acc = psel & penable;
    wire sel_cfg = (paddr == `BLP_OFF_CFG);
    wire sel_lim = (paddr == `BLP_OFF_LIM);
    wire sel_dly = (paddr == `BLP_OFF_DLY);
    wire sel_step = (paddr == `BLP_OFF_STEP);
    wire sel_intv = (paddr == `BLP_OFF_INTV);
    wire sel_skew = (paddr == `BLP_OFF_SKEW);
    wire mapped = sel_cfg | sel_lim | sel_dly | sel_step | sel_intv | sel_skew;
    wire wr = acc & pwrite & mapped;
    wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;

    ////////////////////////////////////////////////////////////////////////
    // configuration register

    logic [31:0] cfg_q;
    logic upd_q;
    logic [7:0] skew_q;
    logic [31:0] lim_a;
    logic [31:0] dly_a;
    logic [31:0] step_a;
    logic [31:0] intv_a;
    logic period_end;
    logic guard_exp;

    wire wr_cfg = wr & sel_cfg;
    wire soft_rst = wr_cfg & pstrb[0] & pwdata[`BLP_CFG_RST];
    wire upd_set = wr_cfg & pstrb[0] & pwdata[`BLP_CFG_UPD];
    wire [31:0] cfg_wr = ((cfg_q & ~wmask) | (pwdata & wmask)) & `BLP_CFG_MASK;

    wire [1:0] ctrl = cfg_q[`BLP_CFG_CTRL_HI:`BLP_CFG_CTRL_LO];
    wire [1:0] counter_width_param = cfg_q[`BLP_CFG_SIZE_HI:`BLP_CFG_SIZE_LO];
    wire [7:0] guard_reload = cfg_q[`BLP_CFG_WDT_HI:`BLP_CFG_WDT_LO];
    wire mirror = cfg_q[`BLP_CFG_SYM];
    wire sys_src = cfg_q[`BLP_CFG_CLK];
    wire is_breath = (ctrl == `BLP_CTRL_BREATH);
    wire is_blink = (ctrl == `BLP_CTRL_BLINK);
    wire running = is_breath | is_blink;
    wire hold_all = cfg_q[`BLP_CFG_SYNC] | sync_in;
    wire copy_cfg = period_end & upd_q;

    assign sync_out = cfg_q[`BLP_CFG_SYNC];

    // written values act on the next edge, no period wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `BLP_CFG_RESET;
        end else if (soft_rst) begin
            cfg_q <= `BLP_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= cfg_wr;
        end else if (guard_exp) begin
            cfg_q[`BLP_CFG_CTRL_HI:`BLP_CFG_CTRL_LO] <= `BLP_CTRL_ON;
        end
    end

    // a set in the cycle of the hardware clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_q <= 1'b0;
        end else if (soft_rst) begin
            upd_q <= 1'b0;
        end else if (upd_set) begin
            upd_q <= 1'b1;
        end else if (copy_cfg) begin
            upd_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skew_q <= 8'h00;
        end else if (soft_rst) begin
            skew_q <= 8'h00;
        end else if (wr & sel_skew & pstrb[0]) begin
            skew_q <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // staged registers

    blp_stage_reg #(.W(32), .MASK(`BLP_LIM_MASK)) u_lim (
        .pclk(pclk),
        .presetn(presetn),
        .clr(soft_rst),
        .wr_en(wr & sel_lim),
        .wr_mask(wmask),
        .wr_data(pwdata),
        .copy(period_end),
        .active_q(lim_a)
    );

    blp_stage_reg #(.W(32), .MASK(`BLP_DLY_MASK)) u_dly (
        .pclk(pclk),
        .presetn(presetn),
        .clr(soft_rst),
        .wr_en(wr & sel_dly),
        .wr_mask(wmask),
        .wr_data(pwdata),
        .copy(copy_cfg),
        .active_q(dly_a)
    );

    blp_stage_reg #(.W(32), .MASK(`BLP_FULL_MASK)) u_step (
        .pclk(pclk),
        .presetn(presetn),
        .clr(soft_rst),
        .wr_en(wr & sel_step),
        .wr_mask(wmask),
        .wr_data(pwdata),
        .copy(copy_cfg),
        .active_q(step_a)
    );

    blp_stage_reg #(.W(32), .MASK(`BLP_FULL_MASK)) u_intv (
        .pclk(pclk),
        .presetn(presetn),
        .clr(soft_rst),
        .wr_en(wr & sel_intv),
        .wr_mask(wmask),
        .wr_data(pwdata),
        .copy(copy_cfg),
        .active_q(intv_a)
    );

    ////////////////////////////////////////////////////////////////////////
    // read path, captured in the setup cycle so it is stable in access

    wire [31:0] cfg_rd = cfg_q | {25'h000_0000, upd_q, 6'h00};
    wire [31:0] rd_mux = sel_cfg ? cfg_rd :
                         sel_lim ? lim_a :
                         sel_dly ? dly_a :
                         sel_step ? step_a :
                         sel_intv ? intv_a :
                         sel_skew ? {24'h00_0000, skew_q} : `BLP_ZERO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `BLP_ZERO;
        end else if (psel & ~penable) begin
            prdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slow tick and pwm counter

    logic [12:0] slow_q;
    logic [11:0] presc_q;
    logic [7:0] ctr_q;

    wire tick_slow = (slow_q == 13'(SLOW_DIV - 1));
    wire src_tick = sys_src ? 1'b1 : tick_slow;
    wire [11:0] ld = dly_a[`BLP_DLY_LD_HI:`BLP_DLY_LD_LO];
    wire [11:0] hd = dly_a[`BLP_DLY_HD_HI:`BLP_DLY_HD_LO];
    wire presc_wrap = src_tick & (presc_q >= ld);
    wire adv = is_blink ? presc_wrap : tick_slow;
    wire clr_cnt = ~running | hold_all | soft_rst;
    wire pwm_adv = ~clr_cnt & adv;
    wire [1:0] sh = (is_blink | (counter_width_param == 2'h3)) ? `BLP_SIZE8 : counter_width_param;
    wire [7:0] top = (sh == `BLP_SIZE7) ? `BLP_TOP7 :
                     (sh == `BLP_SIZE6) ? `BLP_TOP6 : `BLP_TOP8;
    wire [7:0] ctr_inc = 8'h01 << sh;

    assign period_end = pwm_adv & (ctr_q == top);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_q <= 13'h0000;
        end else begin
            slow_q <= tick_slow ? 13'h0000 : slow_q + 13'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= 12'h000;
        end else if (clr_cnt | ~is_blink) begin
            presc_q <= 12'h000;
        end else if (src_tick) begin
            presc_q <= presc_wrap ? 12'h000 : presc_q + 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctr_q <= 8'h00;
        end else if (clr_cnt) begin
            ctr_q <= 8'h00;
        end else if (pwm_adv) begin
            ctr_q <= period_end ? 8'h00 : ctr_q + ctr_inc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // breathing ramp

    blp_pkg::blp_ramp_t st_q, st_d;
    logic [7:0] duty_q, duty_d;
    logic [11:0] hcnt_q, hcnt_d;
    logic [3:0] icnt_q, icnt_d;

    wire [7:0] lim_max = lim_a[`BLP_LIM_MAX_HI:`BLP_LIM_MAX_LO];
    wire [7:0] lim_min = lim_a[`BLP_LIM_MIN_HI:`BLP_LIM_MIN_LO];
    wire falling = (st_q == blp_pkg::st_fall);
    wire [2:0] seg = mirror ? {falling, duty_q[7:6]} : duty_q[7:5];
    wire [3:0] step_nib = seg_nib(step_a, seg);
    wire [3:0] intv_nib = seg_nib(intv_a, seg);
    wire [7:0] amt_base = {4'h0, step_nib >> sh};
    // low field bits are dropped at narrower widths, the step scales back up
    wire [7:0] amt = (amt_base + 8'h01) << sh;
    wire [8:0] up_sum = {1'b0, duty_q} + {1'b0, amt};
    wire [7:0] duty_up = up_sum[8] ? 8'hFF : up_sum[7:0];
    wire [7:0] duty_dn = (duty_q < amt) ? 8'h00 : duty_q - amt;
    wire ramp_clr = (ctrl == `BLP_CTRL_OFF) | soft_rst;
    wire icnt_done = (icnt_q == intv_nib);

    always_comb begin
        st_d = st_q;
        duty_d = duty_q;
        hcnt_d = hcnt_q;
        icnt_d = icnt_q;
        if (ramp_clr) begin
            st_d = blp_pkg::st_rise;
            duty_d = 8'h00;
            hcnt_d = 12'h000;
            icnt_d = 4'h0;
        end else if (hold_all) begin
            hcnt_d = 12'h000;
            icnt_d = 4'h0;
        end else if (is_breath & period_end) begin
            unique case (st_q)
                blp_pkg::st_rise: begin
                    if (duty_q >= lim_max) begin
                        st_d = blp_pkg::st_hold_top;
                        hcnt_d = 12'h000;
                    end else if (icnt_done) begin
                        icnt_d = 4'h0;
                        duty_d = duty_up;
                    end else begin
                        icnt_d = icnt_q + 4'h1;
                    end
                end
                blp_pkg::st_hold_top: begin
                    if (hcnt_q == hd) begin
                        st_d = blp_pkg::st_fall;
                        icnt_d = 4'h0;
                        duty_d = duty_dn;
                    end else begin
                        hcnt_d = hcnt_q + 12'h001;
                    end
                end
                blp_pkg::st_fall: begin
                    if (duty_q <= lim_min) begin
                        st_d = blp_pkg::st_hold_bot;
                        hcnt_d = 12'h000;
                    end else if (icnt_done) begin
                        icnt_d = 4'h0;
                        duty_d = duty_dn;
                    end else begin
                        icnt_d = icnt_q + 4'h1;
                    end
                end
                blp_pkg::st_hold_bot: begin
                    if (hcnt_q == ld) begin
                        st_d = blp_pkg::st_rise;
                        icnt_d = 4'h0;
                        duty_d = duty_up;
                    end else begin
                        hcnt_d = hcnt_q + 12'h001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= blp_pkg::st_rise;
            duty_q <= 8'h00;
            hcnt_q <= 12'h000;
            icnt_q <= 4'h0;
        end else begin
            st_q <= st_d;
            duty_q <= duty_d;
            hcnt_q <= hcnt_d;
            icnt_q <= icnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // guard timer: counts base ticks while blinking or breathing

    logic [31:0] gdiv_q;
    logic [7:0] gcnt_q;

    wire guard_on = running & (guard_reload != 8'h00);
    // a configuration write reloads from the value being written, not the old one
    wire [7:0] guard_load = wr_cfg ? cfg_wr[`BLP_CFG_WDT_HI:`BLP_CFG_WDT_LO] : guard_reload;
    wire gtick = (gdiv_q == 32'(GUARD_TICK_CYC - 1));
    assign guard_exp = guard_on & gtick & (gcnt_q == 8'h01) & ~wr_cfg;

    // any write to the configuration register reloads the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gdiv_q <= 32'h0000_0000;
            gcnt_q <= 8'h00;
        end else if (~guard_on | wr_cfg) begin
            gdiv_q <= 32'h0000_0000;
            gcnt_q <= guard_load;
        end else if (gtick) begin
            gdiv_q <= 32'h0000_0000;
            gcnt_q <= gcnt_q - 8'h01;
        end else begin
            gdiv_q <= gdiv_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // led output

    wire [7:0] duty_eff = is_blink ? lim_min : duty_q;
    wire led_d = (ctrl == `BLP_CTRL_ON) | (running & (ctr_q < duty_eff));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_out <= 1'b0;
        end else begin
            led_out <= led_d;
        end
    end
endmodule

// [bench/blp_top_props.sv]
// concurrent checks on the ports of the led pwm block
// assumes: bound to blp_top, one clock domain, apb answered with no wait states
`timescale 1ns/1ps
`include "blp_regs.svh"
module blp_top_props #(
    parameter int GUARD_TICK_CYC = 16,
    parameter int SLOW_DIV = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sync_in,
    input wire logic sync_out,
    input wire logic led_out
);
    wire logic acc = psel && penable;
    wire logic mapped = paddr == `BLP_OFF_CFG || paddr == `BLP_OFF_LIM ||
        paddr == `BLP_OFF_DLY || paddr == `BLP_OFF_STEP ||
        paddr == `BLP_OFF_INTV || paddr == `BLP_OFF_SKEW;
    // byte 0 carries control, align and the soft reset bit
    wire logic wr_cfg = acc && pwrite && paddr == `BLP_OFF_CFG && pstrb[0];
    wire logic wr_cfg_plain = wr_cfg && !pwdata[`BLP_CFG_RST];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    pready_high_a: assert property (pready) else $error("pready dropped");
    err_in_access_a: assert property (pslverr |-> acc) else $error("stray pslverr");
    unmapped_err_a: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
    cfg_read_a: assert property (acc && !pwrite && paddr == `BLP_OFF_CFG |->
        (prdata & 32'hFFFE_0080) == 32'h0000_0000) else $error("cfg reserved or reset bit set");
    sync_follow_a: assert property (wr_cfg_plain |=> sync_out == $past(pwdata[3]))
        else $error("align bit not applied at once");
    soft_reset_a: assert property (wr_cfg && pwdata[`BLP_CFG_RST] |=> !sync_out)
        else $error("soft reset left align bit");
    on_mode_a: assert property (wr_cfg_plain && pwdata[1:0] == 2'h3 |-> ##[1:3] led_out)
        else $error("always on not driven");
    off_mode_a: assert property (wr_cfg_plain && pwdata[1:0] == 2'h0 |-> ##[1:3] !led_out)
        else $error("off mode still driving");
    hold_led_a: assert property ((sync_in && !psel) [*4] |-> $stable(led_out))
        else $error("led moved while counters held");
endmodule
bind blp_top blp_top_props #(.GUARD_TICK_CYC(GUARD_TICK_CYC), .SLOW_DIV(SLOW_DIV))
    blp_top_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_in(sync_in), .sync_out(sync_out),
    .led_out(led_out));

// [bench/blp_top_tb.sv]
// self-checking bench for the led pwm block, driven over apb
// assumes: short guard and slow-tick parameters so that every count fits the run
`timescale 1ns/1ps
module blp_top_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic sync_in = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sync_out, led_out;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int p1, h1, p2, h2, p3, h3;

    blp_top #(.GUARD_TICK_CYC(16), .SLOW_DIV(4)) blp_top_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_in(sync_in), .sync_out(sync_out), .led_out(led_out));

    initial begin
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // a hung handshake ends up here; measure gives up after 10000 cycles (two waits of 5000) on a led that never toggles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk32(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD %0t value %h expected %h", $time, g, x);
        end
    endtask

    task automatic chk1(input logic g, input logic x);
        n_compared++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD %0t bit %b expected %b", $time, g, x);
        end
    endtask

    task automatic chkn(input int g, input int x);
        n_compared++;
        if (g != x) begin
            n_mismatch++;
            $display("BAD %0t count %0d expected %0d", $time, g, x);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait for the answer
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, s, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0000_0000, 4'h0, r, e);
        chk32(r, x);
    endtask

    // cycles from one rising led edge to the next, and how long it stays high
    task automatic measure(output int per, output int hi);
        logic p;
        int n;
        p = 1'b1;
        for (n = 0; n < 5000; n++) begin
            @(posedge pclk);
            if (led_out === 1'b1 && p === 1'b0) break;
            p = led_out;
        end
        per = 1;
        hi = 1;
        p = 1'b1;
        for (n = 0; n < 5000; n++) begin
            @(posedge pclk);
            if (led_out === 1'b1 && p === 1'b0) break;
            per++;
            if (led_out === 1'b1) hi++;
            p = led_out;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd(8'h00, 32'h0000_1400);
        for (int i = 1; i < 6; i++) begin
            rd(8'(4 * i), 32'h0000_0000);
        end
        apb(8'h18, 1'b0, 32'h0000_0000, 4'h0, r, e);
        chk1(e, 1'b1);
        chk32(r, 32'h0000_0000);
    endtask

    task automatic t_stage();
        wr(8'h0C, 32'h1234_5678, 4'hF);
        wr(8'h04, 32'h0000_FF80, 4'hF);
        rd(8'h0C, 32'h0000_0000);
        rd(8'h04, 32'h0000_0000);
        // holding the counters keeps a period end out of the pending window
        @(posedge pclk) sync_in <= 1'b1;
        wr(8'h00, 32'h0000_0046, 4'hF);
        rd(8'h00, 32'h0000_0046);
        rd(8'h0C, 32'h0000_0000);
        // a quiet stretch with the counters held
        repeat (6) @(posedge pclk);
        @(posedge pclk) sync_in <= 1'b0;
        repeat (600) @(posedge pclk);
        rd(8'h0C, 32'h1234_5678);
        rd(8'h00, 32'h0000_0006);
        rd(8'h04, 32'h0000_FF80);
        wr(8'h0C, 32'hFFFF_FFFF, 4'hF);
        repeat (600) @(posedge pclk);
        rd(8'h0C, 32'h1234_5678);
    endtask

    task automatic t_blink();
        measure(p1, h1);
        chkn(p1, 256);
        chkn(h1, 128);
        wr(8'h04, 32'h0000_0040, 4'h1);
        repeat (600) @(posedge pclk);
        rd(8'h04, 32'h0000_FF40);
        wr(8'h08, 32'h0000_0001, 4'hF);
        wr(8'h00, 32'h0000_0066, 4'hF);
        repeat (1200) @(posedge pclk);
        rd(8'h00, 32'h0000_0026);
        measure(p1, h1);
        chkn(p1, 512);
        chkn(h1, 128);
        wr(8'h00, 32'h0000_0022, 4'hF);
        measure(p1, h1);
        measure(p1, h1);
        chkn(p1, 2048);
        chkn(h1, 512);
    endtask

    task automatic t_breath();
        wr(8'h00, 32'h0000_0000, 4'hF);
        wr(8'h04, 32'h0000_FF00, 4'hF);
        wr(8'h08, 32'h0000_0000, 4'hF);
        wr(8'h10, 32'h0000_0000, 4'hF);
        wr(8'h00, 32'h0000_0041, 4'hF);
        measure(p1, h1);
        measure(p2, h2);
        measure(p3, h3);
        chkn(p3, 1024);
        chkn(h3 - h2, 128);
    endtask

    task automatic t_modes();
        wr(8'h00, 32'h0000_0003, 4'hF);
        repeat (4) @(posedge pclk);
        chk1(led_out, 1'b1);
        wr(8'h00, 32'h0000_0008, 4'hF);
        repeat (4) @(posedge pclk);
        chk1(led_out, 1'b0);
        chk1(sync_out, 1'b1);
        wr(8'h00, 32'h0000_0000, 4'hF);
        @(posedge pclk);
        chk1(sync_out, 1'b0);
    endtask

    task automatic t_guard();
        wr(8'h00, 32'h0000_0101, 4'hF);
        repeat (40) @(posedge pclk);
        rd(8'h00, 32'h0000_0103);
        chk1(led_out, 1'b1);
    endtask

    task automatic t_soft();
        wr(8'h04, 32'h0000_1234, 4'hF);
        wr(8'h00, 32'h0001_0000, 4'hC);
        rd(8'h00, 32'h0001_0103);
        wr(8'h00, 32'h0000_0080, 4'h1);
        rd(8'h00, 32'h0000_1400);
        rd(8'h04, 32'h0000_0000);
        rd(8'h0C, 32'h0000_0000);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_stage();
        t_blink();
        t_breath();
        t_modes();
        t_guard();
        t_soft();
        final_report();
    end
endmodule
